// File: hw/apnm_regs.svh
/*
  Timing and layout constants for the page-mode memory host port.
  Assumes a 100 MHz controller clock.
*/
`ifndef APNM_REGS_SVH
`define APNM_REGS_SVH
`define APNM_CLK_PERIOD_NS 10
`define APNM_T_RC_NS       70
`define APNM_T_PRC_NS      15
`define APNM_T_WC_NS       320
`define APNM_T_PWC_NS      15
`define APNM_CYC(ns) (((ns) + `APNM_CLK_PERIOD_NS - 1) / `APNM_CLK_PERIOD_NS)
`define APNM_PAGE_LSB      2
`define APNM_CNT_W         6
`endif

// File: hw/apnm_pkg.sv
/*
  Types for the page-mode memory host port.
  Assumes nothing beyond the constants header.
*/
package apnm_pkg;
  typedef enum logic [2:0] {
    APNM_IDLE  = 3'b000,
    APNM_RSTB  = 3'b001,
    APNM_READ  = 3'b011,
    APNM_WRITE = 3'b010,
    APNM_WEHI  = 3'b110,
    APNM_END   = 3'b111
  } apnm_state_t;
endpackage

// File: hw/apnm_host.sv
/*
  Host controller for an asynchronous page-mode non-volatile memory:
  issues word/byte reads and writes on the device pins, pacing each access.
  Assumes the device pins are driven straight from these flip-flops and
  that the data bus wire is resolved outside from data_lines_oe_out.
*/
`timescale 1ns/1ns
`include "apnm_regs.svh"
module apnm_host #(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  // User request port
  input  wire logic                 req_valid_in,
  input  wire logic                 req_write_in,
  input  wire logic [ADDR_W-1:0]    req_addr_in,
  input  wire logic [DATA_W-1:0]    req_wdata_in,
  input  wire logic [1:0]           req_lanes_in,
  input  wire logic                 req_last_in,
  input  wire logic                 init_req_in,
  output logic                      req_ready_out,
  output logic                      rsp_valid_out,
  output logic [DATA_W-1:0]         rsp_rdata_out,
  // Device pins
  output logic                      chip_sel_n_out,
  output logic                      write_n_out,
  output logic                      out_gate_n_out,
  output logic                      low_lane_n_out,
  output logic                      high_lane_n_out,
  output logic                      init_n_out,
  output logic [ADDR_W-1:0]         word_address_out,
  input  wire logic [DATA_W-1:0]    data_lines_in,
  output logic [DATA_W-1:0]         data_lines_out,
  output logic [DATA_W-1:0]         data_lines_oe_out
);
  import apnm_pkg::*;

  localparam logic [`APNM_CNT_W-1:0] RC_CYC  = `APNM_CNT_W'(`APNM_CYC(`APNM_T_RC_NS));
  localparam logic [`APNM_CNT_W-1:0] PRC_CYC = `APNM_CNT_W'(`APNM_CYC(`APNM_T_PRC_NS));
  localparam logic [`APNM_CNT_W-1:0] WC_CYC  = `APNM_CNT_W'(`APNM_CYC(`APNM_T_WC_NS));
  localparam logic [`APNM_CNT_W-1:0] PWC_CYC = `APNM_CNT_W'(`APNM_CYC(`APNM_T_PWC_NS));
  // Select must still be low this many sampled cycles after a new-page write opens
  localparam int WC_HOLD = `APNM_CYC(`APNM_T_WC_NS) - 1;

  if (DATA_W != 16 || ADDR_W <= `APNM_PAGE_LSB) begin : g_bad_width
    $error("apnm_host: unsupported width");
  end

  apnm_state_t              state_r;
  logic [`APNM_CNT_W-1:0]   cnt_r;
  logic                     open_r;
  logic                     is_wr_r;
  logic [ADDR_W-1:0]        page_r;
  logic [DATA_W-1:0]        wdata_r;
  logic [1:0]               lanes_r;
  logic                     last_r;
  logic                     same_page;
  logic                     lane_lo;
  logic                     lane_hi;

  // Page compare ignores the in-page word bits
  assign same_page = open_r && (req_write_in == is_wr_r) &&
    (req_addr_in[ADDR_W-1:`APNM_PAGE_LSB] == page_r[ADDR_W-1:`APNM_PAGE_LSB]);
  assign req_ready_out = (state_r == APNM_IDLE || state_r == APNM_END) && !init_req_in;
  assign lane_lo = lanes_r[0];
  assign lane_hi = lanes_r[1];

  // Sequencer; select stays low across a page burst so in-page timing applies
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= APNM_IDLE;
      cnt_r   <= '0;
      open_r  <= 1'b0;
      is_wr_r <= 1'b0;
      page_r  <= '0;
      wdata_r <= '0;
      lanes_r <= 2'b00;
      last_r  <= 1'b1;
    end else begin
      case (state_r)
        APNM_IDLE, APNM_END: begin
          if (init_req_in && !open_r) begin
            state_r <= APNM_RSTB;
            cnt_r   <= WC_CYC;
          end else if (req_valid_in && req_ready_out) begin
            is_wr_r <= req_write_in;
            page_r  <= req_addr_in;
            wdata_r <= req_wdata_in;
            lanes_r <= req_lanes_in;
            last_r  <= req_last_in;
            open_r  <= 1'b1;
            if (req_write_in) begin
              state_r <= APNM_WRITE;
              cnt_r   <= same_page ? PWC_CYC : WC_CYC;
            end else begin
              state_r <= APNM_READ;
              cnt_r   <= same_page ? PRC_CYC : RC_CYC;
            end
          end else if (open_r && state_r == APNM_IDLE) begin
            open_r <= 1'b0; // No follow-on request: close and commit
          end else begin
            state_r <= APNM_IDLE;
          end
        end
        APNM_RSTB: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == 1) state_r <= APNM_IDLE;
        end
        APNM_WRITE: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == 1) state_r <= APNM_WEHI;
        end
        APNM_READ: begin
          // One edge longer than a write: the pins lag the loaded count by an edge,
          // so ending at zero keeps the full access time before data is sampled
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == '0) begin
            state_r <= APNM_END;
            if (last_r) open_r <= 1'b0;
          end
        end
        APNM_WEHI: begin
          state_r <= APNM_END; // Strobe high at least three cycles before the next fall
          if (last_r) open_r <= 1'b0;
        end
        default: state_r <= APNM_IDLE;
      endcase
    end
  end

  // Pin drive; select held high from reset until an access opens
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      chip_sel_n_out   <= 1'b1;
      write_n_out      <= 1'b1;
      out_gate_n_out   <= 1'b1;
      low_lane_n_out   <= 1'b1;
      high_lane_n_out  <= 1'b1;
      init_n_out       <= 1'b1;
      word_address_out <= '0;
      data_lines_out   <= '0;
      data_lines_oe_out <= '0;
    end else begin
      chip_sel_n_out  <= !(open_r || state_r == APNM_READ || state_r == APNM_WRITE
                           || state_r == APNM_WEHI);
      init_n_out      <= !(state_r == APNM_RSTB);
      // Strobe falls with the settled address and rises to latch data
      write_n_out     <= !(state_r == APNM_WRITE && cnt_r != 1);
      out_gate_n_out  <= !(state_r == APNM_READ);
      low_lane_n_out  <= !((state_r == APNM_READ || state_r == APNM_WRITE) && lane_lo);
      high_lane_n_out <= !((state_r == APNM_READ || state_r == APNM_WRITE) && lane_hi);
      // Address moves at the take edge, a full cycle before the strobe falls
      if (req_valid_in && req_ready_out)
        word_address_out <= req_addr_in;
      data_lines_out  <= wdata_r;
      // Drive only enabled lanes while writing; lanes float for reads
      data_lines_oe_out <= (state_r == APNM_WRITE)
        ? {{8{lane_hi}}, {8{lane_lo}}} : '0;
    end
  end

  // Read capture on the last cycle of the access window
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end else begin
      rsp_valid_out <= (state_r == APNM_READ && cnt_r == '0);
      if (state_r == APNM_READ && cnt_r == '0)
        rsp_rdata_out <= {lane_hi ? data_lines_in[15:8] : 8'h00,
                          lane_lo ? data_lines_in[7:0]  : 8'h00};
    end
  end

  chk_float_on_read: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !out_gate_n_out |-> data_lines_oe_out == '0) else $error("bus driven during read");
  chk_idle_select: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    chip_sel_n_out |-> (write_n_out && data_lines_oe_out == '0)) else $error("active while deselected");
  chk_write_lanes: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!write_n_out && low_lane_n_out) |-> data_lines_oe_out[7:0] == 8'h00)
    else $error("lower lane driven while disabled");
  chk_write_hilane: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!write_n_out && high_lane_n_out) |-> data_lines_oe_out[15:8] == 8'h00)
    else $error("upper lane driven while disabled");
  chk_write_sel: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !write_n_out |-> !chip_sel_n_out) else $error("strobe without select");
  chk_read_min: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(out_gate_n_out) |-> !out_gate_n_out[*2]) else $error("read window too short");
  chk_write_min: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    ($fell(chip_sel_n_out) && $fell(write_n_out)) |-> ##WC_HOLD !chip_sel_n_out)
    else $error("write cycle too short");
  chk_page_addr: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!write_n_out && $past(!write_n_out)) |-> $stable(word_address_out))
    else $error("address moved under strobe");
  chk_no_lanes: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!write_n_out && low_lane_n_out && high_lane_n_out) |-> data_lines_oe_out == '0)
    else $error("bus driven with no lane");
  chk_read_resp: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(out_gate_n_out) |-> ##[1:8] rsp_valid_out) else $error("read answer missing");
  chk_init_pulse: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    !init_n_out |-> chip_sel_n_out) else $error("init with select low");
endmodule // apnm_host

// File: verification/apnm_mem_model.sv
/* Behavioural page-mode memory, 64 words deep.
   Assumes the bench resolves the data wire from both enables. */
`timescale 1ns/1ns
module apnm_mem_model (
  // Device pins
  input  wire logic        cs_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        lo_n_in,
  input  wire logic        hi_n_in,
  input  wire logic        init_n_in,
  input  wire logic [20:0] addr_in,
  input  wire logic [15:0] dq_in,
  // Data drive
  output logic      [15:0] dq_out,
  output logic      [15:0] dq_oe_out
);
  logic [15:0] mem_r [0:63] = '{default: 16'h0000};
  logic [15:0] pend_r [0:3];
  logic [1:0]  mask_r [0:3] = '{default: 2'h0};
  logic [1:0]  off_r;
  logic [3:0]  page_r;
  logic        rd;
  assign rd = !cs_n_in && we_n_in && !oe_n_in && init_n_in;
  assign dq_oe_out = {{8{rd && !hi_n_in}}, {8{rd && !lo_n_in}}};
  assign dq_out = mem_r[addr_in[5:0]];
  always @(negedge we_n_in) if (!cs_n_in && init_n_in) begin
    off_r = addr_in[1:0];
    page_r = addr_in[5:2];
  end
  // Lane mask kept per word so a partial write never touches the other byte
  always @(posedge we_n_in) if (!cs_n_in && init_n_in) begin
    pend_r[off_r] = dq_in;
    mask_r[off_r] = ~{hi_n_in, lo_n_in};
  end
  always @(posedge cs_n_in or negedge init_n_in) begin
    for (int i = 0; i < 4; i++) begin
      if (init_n_in && mask_r[i][0]) mem_r[{page_r, i[1:0]}][7:0] = pend_r[i][7:0];
      if (init_n_in && mask_r[i][1]) mem_r[{page_r, i[1:0]}][15:8] = pend_r[i][15:8];
      mask_r[i] = 2'h0;
    end
  end
endmodule // apnm_mem_model

// File: verification/apnm_host_tb_top.sv
/* Self-checking bench for the page-mode memory host port.
   Assumes the behavioural memory model on the device pins. */
`timescale 1ns/1ns
module apnm_host_tb_top;
  logic        clk = 0, rstn = 0, vld = 0, wr = 0, last = 0, init = 0;
  logic [20:0] addr = '0, wa;
  logic [15:0] wd = '0, flt_r = 16'h5a5a, bus, rd, hd, hoe, md, moe;
  logic [1:0]  lanes = '0;
  logic        rdy, rv, csn, wen, oen, lon, hin, initn;
  int          miscompares = 0, n_checks = 0;
  initial forever #5 clk = ~clk;
  // Undriven wire toggles so a stale value can never pass
  always @(posedge clk) flt_r <= ~flt_r;
  assign bus = (hd & hoe) | (md & moe) | (flt_r & ~hoe & ~moe);
  apnm_host uut (.ref_clk_in(clk), .resetn_in(rstn), .req_valid_in(vld), .req_write_in(wr),
    .req_addr_in(addr), .req_wdata_in(wd), .req_lanes_in(lanes), .req_last_in(last),
    .init_req_in(init), .req_ready_out(rdy), .rsp_valid_out(rv), .rsp_rdata_out(rd),
    .chip_sel_n_out(csn), .write_n_out(wen), .out_gate_n_out(oen), .low_lane_n_out(lon),
    .high_lane_n_out(hin), .init_n_out(initn), .word_address_out(wa), .data_lines_in(bus),
    .data_lines_out(hd), .data_lines_oe_out(hoe));
  apnm_mem_model mem (.cs_n_in(csn), .we_n_in(wen), .oe_n_in(oen), .lo_n_in(lon),
    .hi_n_in(hin), .init_n_in(initn), .addr_in(wa), .dq_in(bus), .dq_out(md), .dq_oe_out(moe));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One request: wt = cycles waited for take, lat = take to read data
  task automatic acc(logic w, logic [20:0] a, logic [15:0] d, logic [1:0] l, logic lst,
                     output int wt, output int lat, output logic [15:0] q);
    wt = 0;
    lat = 0;
    @(posedge clk);
    {vld, wr, addr, wd, lanes, last} <= {1'b1, w, a, d, l, lst};
    do begin
      @(negedge clk);
      wt++;
    end while (rdy !== 1'b1 && wt < 100);
    @(posedge clk);
    vld <= 1'b0;
    while (!w && rv !== 1'b1 && lat < 100) begin
      @(negedge clk);
      lat++;
    end
    q = rd;
    if (wt >= 100 || lat >= 100) begin
      cmp("wait bound", 0, 1);
      stop_test();
    end
  endtask
  task automatic t_word();
    int w, l;
    logic [15:0] q;
    acc(1, 21'h8, 16'h1234, 2'h3, 1, w, l, q);
    acc(1, 21'h9, 16'h5678, 2'h3, 1, w, l, q);
    cmp("write cycle", 1, w >= 32);
    acc(0, 21'h8, 0, 2'h3, 0, w, l, q);
    cmp("word 8", 16'h1234, q);
    cmp("read lat new", 9, l);
    acc(0, 21'h9, 0, 2'h3, 1, w, l, q);
    cmp("word 9", 16'h5678, q);
    cmp("read lat page", 4, l);
  endtask
  task automatic t_lanes();
    int w, l;
    logic [15:0] q;
    acc(1, 21'h8, 16'hee55, 2'h1, 0, w, l, q);
    acc(1, 21'h9, 16'h99ee, 2'h2, 0, w, l, q);
    acc(1, 21'ha, 16'hffff, 2'h0, 1, w, l, q);
    cmp("page write", 1, w >= 2 && w < 32);
    acc(0, 21'h8, 0, 2'h1, 0, w, l, q);
    cmp("low lane", 16'h0055, q);
    acc(0, 21'h9, 0, 2'h2, 0, w, l, q);
    cmp("high lane", 16'h9900, q);
    acc(0, 21'h8, 0, 2'h3, 0, w, l, q);
    cmp("merged 8", 16'h1255, q);
    acc(0, 21'h9, 0, 2'h3, 0, w, l, q);
    cmp("merged 9", 16'h9978, q);
    acc(0, 21'ha, 0, 2'h3, 1, w, l, q);
    cmp("no lane write", 16'h0000, q);
  endtask
  task automatic t_init();
    int n;
    @(posedge clk);
    {init, vld, wr, addr, lanes, last} <= {1'b1, 1'b1, 1'b0, 21'h8, 2'h3, 1'b1};
    for (n = 0; n < 10 && initn !== 1'b0; n++) @(negedge clk);
    cmp("init pin", 0, initn);
    cmp("refused", 0, rdy);
    @(posedge clk);
    {init, vld} <= 2'h0;
    for (n = 0; n < 100 && initn !== 1'b1; n++) @(negedge clk);
    cmp("init end", 1, initn);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    cmp("reset pins", 6'h3f, {csn, wen, oen, lon, hin, initn});
    cmp("reset bus", 0, hoe);
    rstn <= 1'b1;
    t_word();
    t_lanes();
    t_init();
    stop_test();
  end
endmodule // apnm_host_tb_top
